// ### iack_host_pkg.sv
// Constants and carriers for the interrupt acknowledge host controller.
// Assumes a 16-bit device register port and a 32-bit Avalon-MM slave.
package iack_host_pkg;

  // ----------------------------------------------------------------------
  // Avalon register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] AV_CTRL   = 8'h00;
  localparam logic [7:0] AV_LEVEL  = 8'h04;
  localparam logic [7:0] AV_SETUP  = 8'h08;
  localparam logic [7:0] AV_VECTOR = 8'h0C;
  localparam logic [7:0] AV_STRAP  = 8'h10;
  localparam logic [7:0] AV_STATUS = 8'h14;

  localparam int CTRL_START    = 0;
  localparam int CTRL_RAISE    = 1;
  localparam int CTRL_DEV_AUTOVECTOR_REQUEST = 2;
  localparam int CTRL_EXT_AUTOVECTOR_REQUEST = 3;
  localparam int CTRL_ANY      = 4;
  localparam int SU_WAITS_LSB  = 0;
  localparam int SU_PORT16     = 4;
  localparam int SU_CS_LSB     = 8;
  localparam int SU_DCS_LSB    = 12;
  localparam int ST_BUSY       = 0;
  localparam int ST_DONE       = 1;
  localparam int ST_ERR        = 2;
  localparam int ST_PEND       = 3;
  localparam int ST_CNT_LSB    = 8;

  localparam logic [7:0] STRAP_RESET = 8'hFF;
  localparam logic [7:0] STRAP_UPPER = 8'hFF;
  localparam logic [7:0] VECTOR_PAD  = 8'hFF;

  // ----------------------------------------------------------------------
  // Device register port
  // ----------------------------------------------------------------------
  localparam logic [7:0] DEV_PAR0    = 8'h44;
  localparam logic [7:0] DEV_PAR1    = 8'h46;
  localparam logic [7:0] DEV_CS0_BAR = 8'h4C;
  localparam logic [7:0] DEV_OPT_OFS = 8'h02;
  localparam logic [3:0] CS_PAR0_LAST  = 4'h5;
  localparam logic [3:0] CS_PAR1_FIRST = 4'h6;
  localparam logic [3:0] CS_LAST       = 4'hA;

  localparam int           BAR_ONES_LSB = 3;
  localparam logic [12:0]  BAR_ONES     = 13'h1FFF;
  localparam logic [2:0]   BLK_64K      = 3'h3;

  localparam int OPT_MODE      = 15;
  localparam int OPT_BYTE_LSB  = 13;
  localparam int OPT_RW_LSB    = 11;
  localparam int OPT_STROBE_SOURCE_FIELD      = 10;
  localparam int OPT_DATA_SIZE_ACKNOWLEDGE_LSB = 6;
  localparam int OPT_SPACE_LSB = 4;
  localparam int OPT_IPL_LSB   = 1;
  localparam int OPT_AUTOVECTOR_REQUEST      = 0;

  localparam logic [1:0] BYTE_OFF   = 2'h0;
  localparam logic [1:0] BYTE_LOWER = 2'h1;
  localparam logic [1:0] BYTE_UPPER = 2'h2;
  localparam logic [1:0] BYTE_BOTH  = 2'h3;
  localparam logic [1:0] RW_READ    = 2'h1;
  localparam logic [1:0] RW_BOTH    = 2'h3;
  localparam logic [1:0] SPACE_CPU  = 2'h0;
  localparam logic       STROBE_SOURCE_FIELD_AS    = 1'h0;
  localparam logic       MODE_ASYNC = 1'h0;
  localparam logic [3:0] DATA_SIZE_ACKNOWLEDGE_EXTERNAL = 4'hF;

  localparam logic [1:0]  PA_DISCRETE = 2'h0;
  localparam logic [1:0]  PA_ALT      = 2'h1;
  localparam logic [1:0]  PA_CS8      = 2'h2;
  localparam logic [1:0]  PA_CS16     = 2'h3;
  localparam logic [15:0] PA_MASK     = 16'h0003;

  // ----------------------------------------------------------------------
  // Acknowledge cycle encoding and pins
  // ----------------------------------------------------------------------
  localparam logic [2:0] FC_CPU     = 3'h7;
  localparam logic [3:0] SPACE_IACK = 4'hF;
  localparam logic [2:0] IPL_ANY    = 3'h0;
  localparam logic [1:0] DATA_SIZE_ACKNOWLEDGE_N_16   = 2'h1;
  localparam logic [1:0] DATA_SIZE_ACKNOWLEDGE_N_8    = 2'h2;
  localparam logic [1:0] DATA_SIZE_ACKNOWLEDGE_N_IDLE = 2'h3;

  typedef struct packed {
    logic [3:0] cs_idx;
    logic [3:0] data_cs;
    logic       port16;
    logic       dev_autovector_request;
    logic       ext_autovector_request;
    logic       any_level;
    logic [2:0] level;
    logic [3:0] waits;
  } host_cfg_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } dev_wr_t;

  typedef struct packed {
    dev_wr_t par;
    dev_wr_t bar;
    dev_wr_t opt;
  } cs_words_t;

endpackage

// ### cs_word_builder.sv
// Builds the three device register words for one acknowledge chip select.
// Assumes pin assignment registers still hold their strap reset values.
`timescale 1ns/10ps
module cs_word_builder
  import iack_host_pkg::*;
(
  input  host_cfg_t  cfg,
  input  logic [7:0] strap,
  output cs_words_t  words
);

  // ----------------------------------------------------------------------
  // Pin assignment shadow from strap levels
  // ----------------------------------------------------------------------
  logic [15:0] par0_strap;
  logic [15:0] par1_strap;
  logic [4:0]  hi_bit;

  assign par0_strap = {2'h0, strap[2], 1'b1, strap[2], 1'b1, strap[2], 1'b1,
                       strap[1], 1'b1, strap[1], 1'b1, strap[1], 1'b1,
                       1'b1, strap[0]};
  assign par1_strap[15:10] = 6'h00;

  genvar k;
  generate
    for (k = 0; k < 5; k++)
    begin : g_par1
      assign hi_bit[k] = &strap[7:3+k];
      assign par1_strap[2*k+1] = hi_bit[k];
      assign par1_strap[2*k] = 1'b1;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Selected field replacement
  // ----------------------------------------------------------------------
  logic        in_par0;
  logic [3:0]  par_pos;
  logic [4:0]  par_sh;
  logic [1:0]  new_fld;
  logic [15:0] par_base;

  assign in_par0  = cfg.cs_idx <= CS_PAR0_LAST;
  assign par_pos  = in_par0 ? 4'(cfg.cs_idx + 4'h1)
                            : 4'(cfg.cs_idx - CS_PAR1_FIRST);
  assign par_sh   = {par_pos, 1'b0};
  assign new_fld  = cfg.dev_autovector_request ? PA_ALT
                  : (cfg.port16 ? PA_CS16 : PA_CS8);
  assign par_base = in_par0 ? par0_strap : par1_strap;

  assign words.par.addr = in_par0 ? DEV_PAR0 : DEV_PAR1;
  assign words.par.data = (par_base & ~(PA_MASK << par_sh))
                        | (16'(new_fld) << par_sh);

  // ----------------------------------------------------------------------
  // Base and option words
  // ----------------------------------------------------------------------
  logic [7:0]  bar_addr;
  logic [15:0] opt_w;

  assign bar_addr        = 8'(DEV_CS0_BAR + {cfg.cs_idx, 2'b00});
  assign words.bar.addr  = bar_addr;
  assign words.bar.data  = {BAR_ONES, BLK_64K};
  assign words.opt.addr  = 8'(bar_addr + DEV_OPT_OFS);
  assign words.opt.data  = opt_w;

  always_comb
  begin
    opt_w = 16'h0000;
    opt_w[OPT_MODE] = MODE_ASYNC;
    opt_w[OPT_BYTE_LSB +: 2] = cfg.dev_autovector_request ? BYTE_BOTH
                             : (cfg.port16 ? BYTE_LOWER : BYTE_UPPER);
    opt_w[OPT_RW_LSB +: 2] = cfg.dev_autovector_request ? RW_BOTH : RW_READ;
    opt_w[OPT_STROBE_SOURCE_FIELD] = STROBE_SOURCE_FIELD_AS;
    opt_w[OPT_DATA_SIZE_ACKNOWLEDGE_LSB +: 4] = cfg.waits;
    opt_w[OPT_SPACE_LSB +: 2] = SPACE_CPU;
    opt_w[OPT_IPL_LSB +: 3] = cfg.any_level ? IPL_ANY : cfg.level;
    opt_w[OPT_AUTOVECTOR_REQUEST] = cfg.dev_autovector_request;
  end

endmodule

// ### iack_host_ctrl.sv
// Host controller: programs an acknowledge chip select, raises an external
// interrupt and answers the acknowledge cycle, and drives reset straps.
// Assumes device pins synchronous to core_clk and one Avalon-MM master.
`timescale 1ns/10ps
module iack_host_ctrl
  import iack_host_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             cfg_wr,
  output logic      [7:0]  cfg_addr,
  output logic      [15:0] cfg_wdata,
  input  wire logic        cfg_ack,
  input  wire logic        dev_reset_n,
  input  wire logic [2:0]  function_code,
  input  wire logic [23:0] addr,
  input  wire logic        address_strobe_n,
  input  wire logic        cs_n,
  output logic             irq_n,
  output logic             autovector_request_n,
  output logic      [1:0]  data_size_acknowledge_n,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic             data_oe
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_sync_n;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Avalon slave
  // ----------------------------------------------------------------------
  host_cfg_t  cfg;
  logic [7:0] vector;
  logic [7:0] strap;
  logic       done;
  logic       err;
  logic       irq_pend;
  logic [7:0] ack_count;
  logic       busy;

  wire        wr_take  = write && !waitrequest;
  wire        wr_ctrl  = wr_take && address == AV_CTRL && byteenable[0];
  wire        wr_lvl   = wr_take && address == AV_LEVEL && byteenable[0];
  wire        wr_su_lo = wr_take && address == AV_SETUP && byteenable[0];
  wire        wr_su_hi = wr_take && address == AV_SETUP && byteenable[1];
  wire        wr_vec   = wr_take && address == AV_VECTOR && byteenable[0];
  wire        wr_strap = wr_take && address == AV_STRAP && byteenable[0];
  wire        wr_stat  = wr_take && address == AV_STATUS && byteenable[0];
  wire        start    = wr_ctrl && writedata[CTRL_START];
  wire        raise    = wr_ctrl && writedata[CTRL_RAISE];
  wire        clr_done = wr_stat && writedata[ST_DONE];
  wire        clr_err  = wr_stat && writedata[ST_ERR];

  wire [31:0] ctrl_rd  = {27'h0, cfg.any_level, cfg.ext_autovector_request, cfg.dev_autovector_request,
                          2'h0};
  wire [31:0] setup_rd = {16'h0, cfg.data_cs, cfg.cs_idx, 3'h0, cfg.port16,
                          cfg.waits};
  wire [31:0] stat_rd  = {16'h0, ack_count, 4'h0, irq_pend, err, done, busy};
  wire [31:0] rd_mux   = address == AV_CTRL   ? ctrl_rd
                       : address == AV_LEVEL  ? {29'h0, cfg.level}
                       : address == AV_SETUP  ? setup_rd
                       : address == AV_VECTOR ? {24'h0, vector}
                       : address == AV_STRAP  ? {24'h0, strap}
                       : address == AV_STATUS ? stat_rd
                       : 32'h0000_0000;

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end
    else
    begin
      waitrequest <= !((read || write) && waitrequest);
      readdata    <= rd_mux;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cfg    <= '0;
      vector <= 8'h00;
      strap  <= STRAP_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        cfg.dev_autovector_request  <= writedata[CTRL_DEV_AUTOVECTOR_REQUEST];
        cfg.ext_autovector_request  <= writedata[CTRL_EXT_AUTOVECTOR_REQUEST];
        cfg.any_level <= writedata[CTRL_ANY];
      end
      if (wr_lvl)
        cfg.level <= writedata[2:0];
      if (wr_su_lo)
      begin
        cfg.waits  <= writedata[SU_WAITS_LSB +: 4];
        cfg.port16 <= writedata[SU_PORT16];
      end
      if (wr_su_hi)
      begin
        cfg.cs_idx  <= writedata[SU_CS_LSB +: 4];
        cfg.data_cs <= writedata[SU_DCS_LSB +: 4];
      end
      if (wr_vec)
        vector <= writedata[7:0];
      if (wr_strap)
        strap <= writedata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Configuration writes to the device
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CFG_IDLE = 2'b00,
    CFG_PAR  = 2'b01,
    CFG_BAR  = 2'b10,
    CFG_OPT  = 2'b11
  } cfg_state_t;

  cfg_state_t cfg_state;
  cfg_state_t next_cfg_state;
  cs_words_t  words;
  // Start acts a cycle late so mode bits of the same write reach the words
  logic       start_q;

  cs_word_builder u_words (
    .cfg   (cfg),
    .strap (strap),
    .words (words)
  );

  wire conflict = cfg.cs_idx == cfg.data_cs || cfg.cs_idx > CS_LAST;
  wire go       = cfg_state == CFG_IDLE && start_q && !conflict;
  wire refuse   = cfg_state == CFG_IDLE && start_q && conflict;
  wire step     = cfg_state != CFG_IDLE && cfg_ack;
  wire finish   = cfg_state == CFG_OPT && cfg_ack;
  assign busy   = cfg_state != CFG_IDLE;

  always_comb
  begin
    next_cfg_state = cfg_state;
    case (cfg_state)
      CFG_IDLE: if (go) next_cfg_state = CFG_PAR;
      CFG_PAR:  if (cfg_ack) next_cfg_state = CFG_BAR;
      CFG_BAR:  if (cfg_ack) next_cfg_state = CFG_OPT;
      CFG_OPT:  if (cfg_ack) next_cfg_state = CFG_IDLE;
      default:  next_cfg_state = CFG_IDLE;
    endcase
  end

  wire     next_cfg_wr = next_cfg_state != CFG_IDLE;
  dev_wr_t next_wr;
  assign next_wr = next_cfg_state == CFG_PAR ? words.par
                 : next_cfg_state == CFG_BAR ? words.bar : words.opt;

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cfg_state <= CFG_IDLE;
      start_q   <= 1'b0;
      cfg_wr    <= 1'b0;
      cfg_addr  <= 8'h00;
      cfg_wdata <= 16'h0000;
    end
    else
    begin
      cfg_state <= next_cfg_state;
      start_q   <= start;
      cfg_wr    <= next_cfg_wr;
      if (go || step)
      begin
        cfg_addr  <= next_wr.addr;
        cfg_wdata <= next_wr.data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt request and acknowledge answer
  // ----------------------------------------------------------------------
  typedef enum logic {
    RSP_IDLE = 1'b0,
    RSP_HOLD = 1'b1
  } rsp_state_t;

  rsp_state_t rsp_state;

  wire iack_cycle = function_code == FC_CPU && addr[19:16] == SPACE_IACK
                  && &addr[23:20] && &addr[15:4] && addr[0]
                  && addr[3:1] == cfg.level;
  wire need_cs    = !cfg.dev_autovector_request;
  wire hit        = rsp_state == RSP_IDLE && irq_pend && done
                  && !address_strobe_n && iack_cycle
                  && (!need_cs || !cs_n);
  wire vec_self   = cfg.waits == DATA_SIZE_ACKNOWLEDGE_EXTERNAL;
  wire drive_vec  = hit && need_cs && !cfg.ext_autovector_request;
  wire as_end     = rsp_state == RSP_HOLD && address_strobe_n;
  wire strap_on   = !dev_reset_n;

  wire [15:0] vec_word = cfg.port16 ? {VECTOR_PAD, vector}
                                    : {vector, VECTOR_PAD};
  wire [1:0]  vec_ack  = cfg.port16 ? DATA_SIZE_ACKNOWLEDGE_N_16 : DATA_SIZE_ACKNOWLEDGE_N_8;

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rsp_state <= RSP_IDLE;
      irq_pend  <= 1'b0;
      irq_n     <= 1'b1;
      ack_count <= 8'h00;
      done      <= 1'b0;
      err       <= 1'b0;
      autovector_request_n    <= 1'b1;
      data_size_acknowledge_n <= DATA_SIZE_ACKNOWLEDGE_N_IDLE;
      data_out  <= 16'h0000;
      data_oe   <= 1'b0;
    end
    else
    begin
      done <= finish || (done && !clr_done);
      err  <= refuse || (err && !clr_err);
      irq_pend <= raise || (irq_pend && !as_end);
      irq_n    <= !(raise || (irq_pend && !as_end));
      if (hit)
        rsp_state <= RSP_HOLD;
      else if (as_end)
        rsp_state <= RSP_IDLE;
      if (as_end)
        ack_count <= 8'(ack_count + 8'h01);
      if (hit && need_cs && cfg.ext_autovector_request)
        autovector_request_n <= 1'b0;
      else if (as_end)
        autovector_request_n <= 1'b1;
      if (drive_vec && vec_self)
        data_size_acknowledge_n <= vec_ack;
      else if (as_end)
        data_size_acknowledge_n <= DATA_SIZE_ACKNOWLEDGE_N_IDLE;
      if (strap_on)
      begin
        data_out <= {STRAP_UPPER, strap};
        data_oe  <= 1'b1;
      end
      else if (drive_vec)
      begin
        data_out <= vec_word;
        data_oe  <= 1'b1;
      end
      else if (as_end || rsp_state == RSP_IDLE)
        data_oe  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);

  wire opt_wr = cfg_wr && cfg_state == CFG_OPT;

  property p_base_ones;
    cfg_wr && cfg_state == CFG_BAR |->
      cfg_wdata[15:BAR_ONES_LSB] == BAR_ONES && cfg_wdata[2:0] == BLK_64K;
  endproperty
  a_base_ones: assert property (p_base_ones)
    else $error("base word not all ones with 64K block");

  property p_opt_space;
    opt_wr |-> cfg_wdata[OPT_SPACE_LSB +: 2] == SPACE_CPU
      && cfg_wdata[OPT_MODE] == MODE_ASYNC && cfg_wdata[OPT_STROBE_SOURCE_FIELD] == STROBE_SOURCE_FIELD_AS;
  endproperty
  a_opt_space: assert property (p_opt_space)
    else $error("option word space, mode or strobe wrong");

  property p_opt_rw;
    opt_wr && !cfg.dev_autovector_request |-> cfg_wdata[OPT_RW_LSB +: 2] == RW_READ;
  endproperty
  a_opt_rw: assert property (p_opt_rw)
    else $error("pin select not read only");

  property p_opt_byte;
    opt_wr && !cfg.dev_autovector_request |-> cfg_wdata[OPT_BYTE_LSB +: 2]
      == (cfg.port16 ? BYTE_LOWER : BYTE_UPPER);
  endproperty
  a_opt_byte: assert property (p_opt_byte)
    else $error("byte qualifier does not match port width");

  property p_autovector_request_async;
    opt_wr && cfg_wdata[OPT_AUTOVECTOR_REQUEST] |-> !cfg_wdata[OPT_MODE];
  endproperty
  a_autovector_request_async: assert property (p_autovector_request_async)
    else $error("autovector with synchronised mode");

  property p_waits;
    opt_wr |-> cfg_wdata[OPT_DATA_SIZE_ACKNOWLEDGE_LSB +: 4] == cfg.waits;
  endproperty
  a_waits: assert property (p_waits)
    else $error("acknowledge field not the wait count");

  property p_refuse;
    refuse |=> cfg_state == CFG_IDLE && !cfg_wr ##1 err;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("conflicting select was programmed");

  property p_ext_autovector_request;
    hit && need_cs && cfg.ext_autovector_request |=> !autovector_request_n
      && data_size_acknowledge_n == DATA_SIZE_ACKNOWLEDGE_N_IDLE;
  endproperty
  a_ext_autovector_request: assert property (p_ext_autovector_request)
    else $error("autovector pin not asserted");

  property p_release;
    as_end |=> autovector_request_n
      && data_size_acknowledge_n == DATA_SIZE_ACKNOWLEDGE_N_IDLE && irq_n;
  endproperty
  a_release: assert property (p_release)
    else $error("answer held after strobe negation");

  property p_strap;
    strap_on |=> data_oe && data_out[7:0] == $past(strap);
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap levels not driven during device reset");

  c_config: cover property (go ##[1:40] finish);
  c_vector: cover property (drive_vec && vec_self ##[1:20] as_end);
  c_ext:    cover property (hit && cfg.ext_autovector_request ##[1:20] as_end);
  c_refuse: cover property (refuse);

endmodule

// ### iack_dev_model.sv
// Device model: pin assignment registers, one chip select, CPU cycles.
// Assumes straps are sampled from data_out while dev_reset_n is low.
`timescale 1ns/10ps
module iack_dev_model
  import iack_host_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        dev_reset_n,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [15:0] cfg_wdata,
  output logic             cfg_ack,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  input  wire logic        autovector_request_n,
  input  wire logic [1:0]  data_size_acknowledge_n,
  output logic      [2:0]  function_code,
  output logic      [23:0] addr,
  output logic             address_strobe_n,
  output logic             cs_n
);
  logic [15:0] par0, par1, bar, opt;
  logic [3:0]  idx;
  int          nwr;
  // Undriven data lines float to the pull-up level
  wire  [7:0]  s  = data_oe ? data_out[7:0] : 8'hFF;
  wire  [3:0]  ix = 4'((cfg_addr - DEV_CS0_BAR) >> 2);
  wire  [15:0] pw = idx <= CS_PAR0_LAST ? par0 >> {idx, 1'b0} + 2
                                        : par1 >> {idx - 4'h6, 1'b0};
  wire         hit = !address_strobe_n && function_code == FC_CPU
    && addr[23:11] == bar[15:3] && bar[2:0] <= BLK_64K
    && opt[5:4] == SPACE_CPU && opt[11] && opt[14:13] != BYTE_OFF
    && !opt[15] && (opt[3:1] == IPL_ANY || opt[3:1] == addr[3:1]);
  assign cs_n = !(hit && pw[1]);

  initial
  begin
    cfg_ack = 1'b0;
    nwr = 0;
    bar = 16'h0000;
    opt = 16'h0000;
    function_code = 3'h0;
    addr = 24'h000000;
    address_strobe_n = 1'b1;
  end

  always @(posedge core_clk)
  begin
    cfg_ack <= cfg_wr && !cfg_ack;
    if (!dev_reset_n)
    begin
      par0 <= {2'h0, s[2], 1'b1, s[2], 1'b1, s[2], 1'b1, s[1], 1'b1,
               s[1], 1'b1, s[1], 1'b1, 1'b1, s[0]};
      par1 <= {6'h0, s[7], 1'b1, &s[7:6], 1'b1, &s[7:5], 1'b1,
               &s[7:4], 1'b1, &s[7:3], 1'b1};
      bar <= 16'h0000;
      opt <= 16'h0000;
    end
    else if (cfg_wr && cfg_ack)
    begin
      nwr <= nwr + 1;
      if (cfg_addr == DEV_PAR0) par0 <= cfg_wdata & 16'h3FFF | 16'h0002;
      else if (cfg_addr == DEV_PAR1) par1 <= cfg_wdata & 16'h03FF;
      else if (cfg_addr[1]) opt <= cfg_wdata;
      else
      begin
        bar <= cfg_wdata;
        idx <= ix;
      end
    end
  end

  // --------------------------------------------------------------------
  // Acknowledge cycle: how 0 none, 1 pin, 2 acknowledge, 3 internal
  // --------------------------------------------------------------------
  task automatic iack(input logic [2:0] lvl, output logic [1:0] how,
                      output logic [15:0] vec);
    how = 2'd0;
    vec = 16'h0000;
    @(posedge core_clk);
    function_code <= FC_CPU;
    addr <= {20'hFFFFF, lvl, 1'b1};
    address_strobe_n <= 1'b0;
    for (int n = 0; n < 12 && how == 2'd0; n++)
    begin
      @(posedge core_clk);
      if (data_oe) vec = data_out;
      if (!autovector_request_n) how = 2'd1;
      else if (data_size_acknowledge_n != DATA_SIZE_ACKNOWLEDGE_N_IDLE) how = 2'd2;
      else if (hit && (opt[0] ? n > 0 : opt[9:6] != DATA_SIZE_ACKNOWLEDGE_EXTERNAL
               && n > opt[9:6])) how = 2'd3;
    end
    address_strobe_n <= 1'b1;
    function_code <= 3'h0;
    addr <= 24'h000000;
    repeat (2) @(posedge core_clk);
  endtask
endmodule

// ### iack_host_ctrl_tb.sv
// Bench: register access, strap reset and acknowledge cycles.
// Assumes the device model sits on the device pins of the host.
`timescale 1ns/10ps
module iack_host_ctrl_tb
  import iack_host_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic        dev_reset_n = 1'b1;
  logic [31:0] readdata, s;
  logic        waitrequest, cfg_wr, cfg_ack, address_strobe_n, cs_n;
  logic        irq_n, autovector_request_n, data_oe;
  logic [1:0]  data_size_acknowledge_n, f, h;
  logic [7:0]  cfg_addr, vb;
  logic [15:0] cfg_wdata, data_out, o, p, v;
  logic [2:0]  function_code;
  logic [23:0] addr;
  host_cfg_t   c;
  int          fails = 0;
  int          check_count = 0;
  int          n0;
  host_cfg_t   tab [4] = '{
    '{4'h3, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h5, 4'hF},
    '{4'h7, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h2, 4'h2},
    '{4'h9, 4'h0, 1'b1, 1'b0, 1'b1, 1'b0, 3'h1, 4'hF},
    '{4'h1, 4'h0, 1'b1, 1'b1, 1'b0, 1'b1, 3'h6, 4'h4}};
  logic [1:0]  how_exp [4] = '{2'd2, 2'd3, 2'd1, 2'd3};

  always #20 core_clk = ~core_clk;

  iack_host_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .dev_reset_n(dev_reset_n),
    .function_code(function_code), .addr(addr),
    .address_strobe_n(address_strobe_n), .cs_n(cs_n), .irq_n(irq_n),
    .autovector_request_n(autovector_request_n),
    .data_size_acknowledge_n(data_size_acknowledge_n),
    .data_in(16'h0000), .data_out(data_out), .data_oe(data_oe));

  iack_dev_model dev (.core_clk(core_clk), .dev_reset_n(dev_reset_n),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .data_out(data_out), .data_oe(data_oe),
    .autovector_request_n(autovector_request_n),
    .data_size_acknowledge_n(data_size_acknowledge_n),
    .function_code(function_code), .addr(addr),
    .address_strobe_n(address_strobe_n), .cs_n(cs_n));

  // --------------------------------------------------------------------
  // Avalon access and comparison
  // --------------------------------------------------------------------
  task automatic av(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic wait_done(output logic [31:0] q);
    for (int i = 0; i < 30; i++)
    begin
      av(1'b0, AV_STATUS, 32'h0, q);
      if (q[ST_DONE] || q[ST_ERR]) break;
    end
  endtask

  function automatic logic [15:0] exp_par(input logic [3:0] i,
                                          input logic [1:0] fl);
    int ps;
    ps = i <= CS_PAR0_LAST ? 2 * i + 2 : 2 * (i - 6);
    return (i <= CS_PAR0_LAST ? 16'h3F57 : 16'h0355) & ~(16'h3 << ps)
           | 16'(fl) << ps;
  endfunction

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    fails++;
    print_verdict();
  end

  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(AV_STRAP, 32'hFF);
    rd(AV_STATUS, 32'h0);
    rd(AV_CTRL, 32'h0);
    wr(8'h18, 32'hFFFF);
    rd(8'h18, 32'h0);
    $display("test registers done");
    wr(AV_STRAP, 32'hB5);
    rd(AV_STRAP, 32'hB5);
    dev_reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    dev_reset_n <= 1'b1;
    chk(dev.par0, 32'h3F57);
    chk(dev.par1, 32'h0355);
    $display("test straps done");
    for (int k = 0; k < 4; k++)
    begin
      wr(AV_STATUS, 32'h6);
      c = tab[k];
      vb = 8'h40 + 8'(k);
      wr(AV_LEVEL, 32'(c.level));
      wr(AV_VECTOR, 32'(vb));
      wr(AV_SETUP, {16'h0, c.data_cs, c.cs_idx, 3'h0, c.port16, c.waits});
      n0 = dev.nwr;
      wr(AV_CTRL, {27'h0, c.any_level, c.ext_autovector_request, c.dev_autovector_request, 2'b01});
      wait_done(s);
      chk(dev.nwr - n0, 3);
      chk(dev.bar, {BAR_ONES, BLK_64K});
      f = c.dev_autovector_request ? PA_ALT : c.port16 ? PA_CS16 : PA_CS8;
      p = c.cs_idx <= CS_PAR0_LAST ? dev.par0 : dev.par1;
      chk(p, exp_par(c.cs_idx, f));
      o = {MODE_ASYNC,
           c.dev_autovector_request ? BYTE_BOTH : c.port16 ? BYTE_LOWER : BYTE_UPPER,
           c.dev_autovector_request ? RW_BOTH : RW_READ, STROBE_SOURCE_FIELD_AS, c.waits, SPACE_CPU,
           c.any_level ? IPL_ANY : c.level, c.dev_autovector_request};
      chk(dev.opt, o);
      wr(AV_CTRL, {27'h0, c.any_level, c.ext_autovector_request, c.dev_autovector_request, 2'b10});
      rd(AV_STATUS, {16'h0, 8'(k), 8'h0A});
      chk(irq_n, 1'b0);
      if (k == 0)
      begin
        dev.iack(3'h4, h, v);
        chk(h, 2'd0);
      end
      dev.iack(c.level, h, v);
      chk(h, how_exp[k]);
      if (k < 2) chk(v, c.port16 ? {VECTOR_PAD, vb} : {vb, VECTOR_PAD});
      chk(irq_n, 1'b1);
      $display("test case %0d done", k);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(AV_STATUS, 32'h6);
      wr(AV_SETUP, k ? 32'h0B00 : 32'h2200);
      n0 = dev.nwr;
      wr(AV_CTRL, 32'h1);
      wait_done(s);
      chk(s[ST_ERR], 1'b1);
      chk(dev.nwr - n0, 0);
    end
    wr(AV_STATUS, 32'h6);
    rd(AV_STATUS, 32'h0400);
    $display("test refusal done");
    print_verdict();
  end
endmodule
